// [design/cexu_entry.sv]
`timescale 1ns/1ps
module cexu_entry
   import cexu_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // time base
   input wire logic tb_tick_i,
   // completion report from pipeline
   input wire logic cmp_valid_i,
   input wire logic [31:0] cmp_pc_i,
   input wire logic [31:0] cmp_next_pc_i,
   input wire logic cmp_is_fp_i,
   input wire logic cmp_fp_assist_i,
   input wire logic [31:0] cmp_assist_info_i,
   input wire logic cmp_is_syscall_i,
   input wire logic cmp_is_branch_i,
   input wire logic cmp_no_trace_i,
   input wire logic cmp_other_exc_i,
   input wire logic cmp_ctx_change_i,
   input wire logic cmp_handler_first_i,
   input wire logic [31:0] resume_pc_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // redirect to fetch
   output logic redirect_o,
   output logic [31:0] redirect_pc_o,
   output logic ctx_sync_o,
   output logic flush_o,
   output logic [4:0] exc_code_o,
   // state views
   output logic [31:0] machine_state_o,
   output logic dec_pending_o
);
   typedef struct packed {
      logic [31:0] mstate;
      logic [31:0] srpc;
      logic [31:0] srst;
      logic dec_pend;
      logic trace_arm;
      logic [31:0] trace_pc;
      logic redir;
      logic [31:0] redir_pc;
      logic csync;
      logic [4:0] code;
      logic [31:0] rdata;
   } cexu_st_s;
   cexu_st_s q, d;

   cexu_tick_if tif();
   cexu_exc_e sel;
   logic fpu_req, sys_req, fpa_req, trc_req, dec_req;
   logic trace_now;

   // pick the vector base from machine state
   function automatic logic [31:0] vec_addr(input logic ip,
                                            input logic [31:0] off);
      return (ip ? BASE_HIGH : BASE_LOW) | off;
   endfunction

   // status image saved on entry
   function automatic logic [31:0] save_image(input logic [31:0] ms,
                                              input logic keep_info,
                                              input logic [31:0] info);
      logic [31:0] r;
      r = ms & SAVE_COPY_MASK;
      if (keep_info) begin
         r = r | (info & SAVE_INFO_MASK);
      end
      return r;
   endfunction

   // new machine state: keep ME, IP and ILE, little endian from EXCEPTION_LITTLE_ENDIAN
   function automatic logic [31:0] entry_state(input logic [31:0] ms);
      logic [31:0] r;
      r = ms & MS_KEEP_MASK;
      r[msb(MS_ILE)] = ms[msb(MS_ILE)];
      r[msb(MS_LE)] = ms[msb(MS_ILE)];
      return r;
   endfunction

   // decrementer lives in its own module
   assign tif.tick = tb_tick_i;
   assign tif.wr = reg_wr_i && reg_addr_i == REG_DECR;
   assign tif.wdata = reg_wdata_i;
   cexu_decr u_decr (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .t(tif.dec)
   );

   // candidate exceptions: completing instruction, armed trace, pending decrementer
   always_comb begin
      fpu_req = cmp_valid_i && cmp_is_fp_i && !q.mstate[msb(MS_FP)];
      sys_req = cmp_valid_i && cmp_is_syscall_i;
      fpa_req = cmp_valid_i && cmp_fp_assist_i && cmp_is_fp_i
                && q.mstate[msb(MS_FP)];
      trace_now = cmp_valid_i && !cmp_is_syscall_i && !cmp_other_exc_i
                  && !cmp_ctx_change_i && !cmp_no_trace_i
                  && !cmp_handler_first_i && !fpu_req && !fpa_req
                  && (q.mstate[msb(MS_SE)]
                      || (q.mstate[msb(MS_BE)] && cmp_is_branch_i));
      trc_req = q.trace_arm;
      dec_req = q.dec_pend && q.mstate[msb(MS_EE)];
   end

   cexu_prio u_prio (
      .fpu_i(fpu_req),
      .sys_i(sys_req),
      .fpa_i(fpa_req),
      .trc_i(trc_req),
      .dec_i(dec_req),
      .sel_o(sel)
   );

   // the pick must never hold two sources at once
   one_hot_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $onehot0(sel))
      else $error("more than one exception selected");

   // next state: entry, register writes, decrementer request
   always_comb begin
      d = q;
      d.redir = 1'b0;
      d.csync = 1'b0;
      d.code = 5'h00;
      d.rdata = 32'h00000000;
      // trace is reported the cycle after its instruction completes
      d.trace_arm = trace_now;
      d.trace_pc = cmp_next_pc_i;
      // register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            REG_MSTATE: d.mstate = reg_wdata_i;
            REG_SRPC: d.srpc = reg_wdata_i;
            REG_SRST: d.srst = reg_wdata_i;
            default: d.mstate = d.mstate;
         endcase
      end
      if (tif.rise) begin
         d.dec_pend = 1'b1;
      end
      // register reads have no side effect
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_DECR: d.rdata = tif.count;
            REG_MSTATE: d.rdata = q.mstate;
            REG_SRPC: d.rdata = q.srpc;
            REG_SRST: d.rdata = q.srst;
            REG_PEND: d.rdata = {31'h0, q.dec_pend};
            default: d.rdata = 32'h00000000;
         endcase
      end
      if (sel != CEXU_NONE) begin
         d.redir = 1'b1;
         d.code = sel;
         d.srst = save_image(q.mstate, sel == CEXU_FPA,
                             cmp_assist_info_i);
         d.mstate = entry_state(q.mstate);
         // pending trace is consumed by any entry: handler first instr
         d.trace_arm = 1'b0;
         case (sel)
            CEXU_FPU: begin
               d.srpc = cmp_pc_i;
               d.redir_pc = vec_addr(q.mstate[msb(MS_IP)], VEC_FP_UNAVAIL);
            end
            CEXU_SYS: begin
               d.srpc = cmp_next_pc_i;
               d.csync = 1'b1;
               d.redir_pc = vec_addr(d.mstate[msb(MS_IP)], VEC_SYSCALL);
            end
            CEXU_FPA: begin
               d.srpc = cmp_next_pc_i;
               d.redir_pc = vec_addr(q.mstate[msb(MS_IP)], VEC_FP_ASSIST);
            end
            CEXU_TRC: begin
               d.srpc = q.trace_pc;
               d.redir_pc = vec_addr(q.mstate[msb(MS_IP)], VEC_TRACE);
            end
            CEXU_DEC: begin
               d.srpc = resume_pc_i;
               d.dec_pend = tif.rise;
               d.redir_pc = vec_addr(q.mstate[msb(MS_IP)], VEC_DECR);
            end
            default: d.redir = 1'b0;
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '{mstate: MSTATE_RST, default: '0};
      end else begin
         q <= d;
      end
   end

   // outputs; redirect carries base plus offset
   assign redirect_o = q.redir;
   assign redirect_pc_o = q.redir_pc;
   assign ctx_sync_o = q.csync;
   assign flush_o = q.redir;
   assign exc_code_o = q.code;
   assign reg_rdata_o = q.rdata;
   assign machine_state_o = q.mstate;
   assign dec_pending_o = q.dec_pend;

   fpu_vec_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel == CEXU_FPU) |=> redirect_o
         && redirect_pc_o[15:0] == 16'h0800)
      else $error("fp unavailable vector wrong");
   fpu_pc_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel == CEXU_FPU) |=> q.srpc == $past(cmp_pc_i))
      else $error("fp unavailable saved pc wrong");
   save_copy_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel != CEXU_NONE && sel != CEXU_FPA) |=>
         q.srst == ($past(q.mstate) & SAVE_COPY_MASK))
      else $error("status save image wrong");
   ms_rewrite_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel != CEXU_NONE) |=> q.mstate[msb(MS_EE)] == 1'b0
         && q.mstate[msb(MS_LE)] == $past(q.mstate[msb(MS_ILE)]))
      else $error("machine state not rewritten");
   base_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel != CEXU_NONE && q.mstate[msb(MS_IP)]) |=>
         redirect_pc_o[31:20] == 12'hFFF)
      else $error("high base not used");
   dec_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel == CEXU_DEC) |-> q.mstate[msb(MS_EE)] && q.dec_pend)
      else $error("decrementer taken while disabled");
   dec_cancel_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel == CEXU_DEC && !tif.rise) |=> !dec_pending_o)
      else $error("request not cancelled");
   trace_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (sel == CEXU_TRC) |=> !q.mstate[msb(MS_SE)]
         && !q.mstate[msb(MS_BE)] && redirect_pc_o[15:0] == 16'h0D00)
      else $error("trace entry wrong");

   syscall_c: cover property (@(posedge mclk_i) sel == CEXU_SYS);
   dec_c: cover property (@(posedge mclk_i) sel == CEXU_DEC);
   trace_c: cover property (@(posedge mclk_i) sel == CEXU_TRC);
   assist_c: cover property (@(posedge mclk_i) sel == CEXU_FPA);
endmodule

// [common/cexu_pkg.sv]
package cexu_pkg;
   // machine state bit positions (big-endian numbering, bit 0 is msb)
   localparam int MS_POW = 13;
   localparam int MS_ILE = 15;
   localparam int MS_EE = 16;
   localparam int MS_PR = 17;
   localparam int MS_FP = 18;
   localparam int MS_ME = 19;
   localparam int MS_FE0 = 20;
   localparam int MS_SE = 21;
   localparam int MS_BE = 22;
   localparam int MS_FE1 = 23;
   localparam int MS_IP = 25;
   localparam int MS_IR = 26;
   localparam int MS_DR = 27;
   localparam int MS_RI = 30;
   localparam int MS_LE = 31;
   // status save masks, msb = bit 0
   localparam logic [31:0] SAVE_COPY_MASK = 32'h0000FF73;
   localparam logic [31:0] SAVE_INFO_MASK = 32'h783F0000;
   // bits kept in machine state on entry: ME, IP
   localparam logic [31:0] MS_KEEP_MASK = 32'h00001040;
   // vector offsets
   localparam logic [31:0] VEC_FP_UNAVAIL = 32'h00000800;
   localparam logic [31:0] VEC_DECR = 32'h00000900;
   localparam logic [31:0] VEC_SYSCALL = 32'h00000C00;
   localparam logic [31:0] VEC_TRACE = 32'h00000D00;
   localparam logic [31:0] VEC_FP_ASSIST = 32'h00000E00;
   // physical bases picked by the IP bit of machine state
   localparam logic [31:0] BASE_LOW = 32'h00000000;
   localparam logic [31:0] BASE_HIGH = 32'hFFF00000;
   // register port map
   localparam logic [3:0] REG_DECR = 4'h0;
   localparam logic [3:0] REG_MSTATE = 4'h1;
   localparam logic [3:0] REG_SRPC = 4'h2;
   localparam logic [3:0] REG_SRST = 4'h3;
   localparam logic [3:0] REG_PEND = 4'h4;
   // reset values
   localparam logic [31:0] DECR_RST = 32'h00000000;
   localparam logic [31:0] MSTATE_RST = 32'h00000040;
   // one-hot exception selections
   typedef enum logic [4:0] {
      CEXU_NONE = 5'h00,
      CEXU_FPU = 5'h01,
      CEXU_SYS = 5'h02,
      CEXU_FPA = 5'h04,
      CEXU_TRC = 5'h08,
      CEXU_DEC = 5'h10
   } cexu_exc_e;
   // convert big-endian bit number to vector index
   function automatic int msb(input int n);
      return 31 - n;
   endfunction
endpackage

// [common/cexu_tick_if.sv]
`timescale 1ns/1ps
interface cexu_tick_if;
   logic tick;      // time base step
   logic wr;        // software write of count
   logic [31:0] wdata;
   logic [31:0] count;
   logic rise;      // bit 0 went 0 to 1
   modport ctl (output tick, output wr, output wdata,
      input count, input rise);
   modport dec (input tick, input wr, input wdata,
      output count, output rise);
endinterface

// [design/cexu_decr.sv]
`timescale 1ns/1ps
module cexu_decr
   import cexu_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // carrier
   cexu_tick_if.dec t
);
   typedef struct packed {
      logic [31:0] cnt;
      logic rise;
   } cexu_dec_s;
   cexu_dec_s q, d;

   // next count: write wins over step, a read never touches it
   always_comb begin
      d = q;
      if (t.wr) begin
         d.cnt = t.wdata;
      end else if (t.tick) begin
         d.cnt = q.cnt - 32'h00000001;
      end
      d.rise = !q.cnt[31] && d.cnt[31];
   end

   // state register
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '{cnt: DECR_RST, rise: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign t.count = q.cnt;
   assign t.rise = q.rise;

   // passing zero downward raises an edge next cycle
   zero_pass_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (t.tick && !t.wr && q.cnt == 32'h00000000) |=> t.rise)
      else $error("decrement through zero gave no request");
   write_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      t.wr |=> t.count == $past(t.wdata))
      else $error("write did not load count");
   hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (!t.wr && !t.tick) |=> $stable(t.count))
      else $error("count moved without step or write");
endmodule

// [design/cexu_prio.sv]
`timescale 1ns/1ps
module cexu_prio
   import cexu_pkg::*;
(
   // raw candidates
   input wire logic fpu_i,
   input wire logic sys_i,
   input wire logic fpa_i,
   input wire logic trc_i,
   input wire logic dec_i,
   // winner
   output cexu_exc_e sel_o
);
   // fixed order: instruction-caused first, then trace, then decrementer
   always_comb begin
      if (fpu_i) begin
         sel_o = CEXU_FPU;
      end else if (sys_i) begin
         sel_o = CEXU_SYS;
      end else if (fpa_i) begin
         sel_o = CEXU_FPA;
      end else if (trc_i) begin
         sel_o = CEXU_TRC;
      end else if (dec_i) begin
         sel_o = CEXU_DEC;
      end else begin
         sel_o = CEXU_NONE;
      end
   end
endmodule

// [tb/cexu_pipe_model.sv]
`timescale 1ns/1ps
module cexu_pipe_model (
   // clock
   input wire logic mclk_i,
   // fetch redirect from the unit
   input wire logic redir_i,
   input wire logic [31:0] redir_pc_i,
   // completion report
   output logic valid_o,
   output logic [31:0] pc_o,
   output logic [31:0] next_o,
   output logic [7:0] kind_o,
   output logic [31:0] info_o,
   output logic [31:0] resume_o
);
   logic [31:0] pc_q; // address of the next instruction to issue
   assign resume_o = pc_q;
   initial begin
      pc_q = 32'h00010000;
      valid_o = 1'h0;
      pc_o = 32'h0;
      next_o = 32'h0;
      kind_o = 8'h00;
      info_o = 32'h0;
   end
   // one instruction completes at the coming edge
   task automatic retire(input logic [7:0] k, input logic [31:0] n,
      input logic [31:0] i);
      @(posedge mclk_i);
      valid_o <= 1'h1;
      pc_o <= pc_q;
      next_o <= n;
      kind_o <= k;
      info_o <= i;
   endtask
   // pulse ends; stale fields are scrambled so nobody relies on them
   always @(posedge mclk_i) begin
      if (valid_o) begin
         valid_o <= 1'h0;
         pc_o <= ~pc_o;
         next_o <= ~next_o;
         kind_o <= ~kind_o;
         info_o <= ~info_o;
         pc_q <= next_o;
      end
      // fetch follows the vector, this wins over sequential flow
      if (redir_i)
         pc_q <= redir_pc_i;
   end
endmodule

// [tb/tb_cpu_exception_entry_unit.sv]
`timescale 1ns/1ps
module tb_cpu_exception_entry_unit
   import cexu_pkg::*;
;
   logic mclk_i = 1'h0, rst_b_i = 1'h0, tb_tick_i = 1'h0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic [31:0] reg_rdata_o, redirect_pc_o, machine_state_o;
   logic redirect_o, ctx_sync_o, dec_pending_o, flush_o;
   logic [4:0] exc_code_o;
   // partner side of the completion port
   logic cv;
   logic [7:0] ck;
   logic [31:0] cpc, cnx, cinf, rpc;
   // first redirect seen in a window
   logic [4:0] r_code;
   logic [31:0] r_pc;
   logic r_ctx, r_fl;
   int nred, fails = 0, check_count = 0;
   integer seed = 32'h1062;

   always #12.5 mclk_i = ~mclk_i;

   cexu_pipe_model u_pipe (.mclk_i(mclk_i), .redir_i(redirect_o),
      .redir_pc_i(redirect_pc_o), .valid_o(cv), .pc_o(cpc), .next_o(cnx),
      .kind_o(ck), .info_o(cinf), .resume_o(rpc));

   cexu_entry u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .tb_tick_i(tb_tick_i), .cmp_valid_i(cv), .cmp_pc_i(cpc),
      .cmp_next_pc_i(cnx), .cmp_is_fp_i(ck[7]), .cmp_fp_assist_i(ck[6]),
      .cmp_assist_info_i(cinf), .cmp_is_syscall_i(ck[5]),
      .cmp_is_branch_i(ck[4]), .cmp_no_trace_i(ck[3]),
      .cmp_other_exc_i(ck[2]), .cmp_ctx_change_i(ck[1]),
      .cmp_handler_first_i(ck[0]), .resume_pc_i(rpc),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o),
      .ctx_sync_o(ctx_sync_o), .flush_o(flush_o), .exc_code_o(exc_code_o),
      .machine_state_o(machine_state_o), .dec_pending_o(dec_pending_o));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rw(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'h1;
      @(posedge mclk_i);
      reg_wr_i <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rr(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'h1;
      @(posedge mclk_i);
      reg_rd_i <= 1'h0;
      @(negedge mclk_i);
      d = reg_rdata_o;
   endtask

   // fixed window, so a late second entry is counted too
   task automatic wait_redir();
      nred = 0;
      repeat (4) begin
         @(posedge mclk_i);
         #1;
         if (redirect_o === 1'h1) begin
            if (nred == 0) begin
               r_code = exc_code_o;
               r_pc = redirect_pc_o;
               r_ctx = ctx_sync_o;
               r_fl = flush_o;
            end
            nred++;
         end
      end
   endtask

   // kept: check enable, vector select, exception endian
   function automatic logic [31:0] ex_ms(input logic [31:0] m);
      logic [31:0] r;
      r = m & 32'h00011040;
      r[31-MS_LE] = m[31-MS_ILE];
      return r;
   endfunction

   function automatic logic [31:0] ex_st(input logic [31:0] m, i,
      input logic a);
      return (m & 32'h0000FF73) | (a ? (i & 32'h783F0000) : 32'h0);
   endfunction

   task automatic ent_chk(input logic [4:0] cd, input logic [31:0] m, v,
      epc, inf, input logic as);
      logic [31:0] d;
      wait_redir();
      chk(32'(nred), 32'h1);
      chk(32'(r_code), 32'(cd));
      chk(r_pc, (m[31-MS_IP] ? BASE_HIGH : BASE_LOW) + v);
      chk(32'(r_ctx), 32'(cd == CEXU_SYS));
      chk(32'(r_fl), 32'h1);
      chk(machine_state_o, ex_ms(m));
      rr(REG_SRPC, d);
      chk(d, epc);
      rr(REG_SRST, d);
      chk(d, ex_st(m, inf, as));
   endtask

   // 0 fp off, 1 syscall, 2 assist, 3 step, 4 branch, 5 fp beats sc
   task automatic one_exc(input int t);
      logic [31:0] m, nx, inf, v, pc;
      logic [4:0] cd;
      logic [7:0] k;
      logic as;
      m = $random(seed);
      nx = $random(seed);
      inf = $random(seed);
      m[31-MS_EE] = 1'h0;
      m[31-MS_SE] = (t == 1 || t == 3 || t == 5);
      m[31-MS_BE] = (t == 4);
      m[31-MS_FP] = !(t == 0 || t == 5);
      as = (t == 2);
      k = (t == 0) ? 8'h80 : (t == 1) ? 8'h20 : (t == 2) ? 8'hC0 :
         (t == 4) ? 8'h10 : (t == 5) ? 8'hA0 : 8'h00;
      cd = (t == 0 || t == 5) ? CEXU_FPU : (t == 1) ? CEXU_SYS :
         (t == 2) ? CEXU_FPA : CEXU_TRC;
      v = (t == 0 || t == 5) ? VEC_FP_UNAVAIL : (t == 1) ? VEC_SYSCALL :
         (t == 2) ? VEC_FP_ASSIST : VEC_TRACE;
      rw(REG_MSTATE, m);
      pc = u_pipe.pc_q;
      u_pipe.retire(k, nx, inf);
      ent_chk(cd, m, v, (cd == CEXU_FPU) ? pc : nx, inf, as);
   endtask

   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      wrap_up();
   end

   initial begin
      logic [31:0] d, m, pc;
      int n;
      repeat (10) @(posedge mclk_i);
      rst_b_i <= 1'h1;
      rr(REG_MSTATE, d);
      chk(d, MSTATE_RST);
      rr(4'hF, d);
      chk(d, 32'h0);
      chk(32'(dec_pending_o), 32'h0);
      $display("test reset done");
      for (int r = 0; r < 3; r++) begin
         for (int t = 0; t < 6; t++)
            one_exc(t);
      end
      $display("test entry done");
      for (int i = 0; i < 4; i++) begin
         m = $random(seed);
         m[31-MS_EE] = 1'h0;
         m[31-MS_FP] = 1'h1;
         m[31-MS_SE] = 1'h1;
         rw(REG_MSTATE, m);
         u_pipe.retire(8'h01 << i, $random(seed), $random(seed));
         wait_redir();
         chk(32'(nred), 32'h0);
      end
      $display("test no trace done");
      n = ($random(seed) & 3) + 1;
      rw(REG_DECR, 32'(n));
      tb_tick_i <= 1'h1;
      repeat (n + 1) @(posedge mclk_i);
      tb_tick_i <= 1'h0;
      rr(REG_DECR, d);
      chk(d, 32'hFFFFFFFF);
      rr(REG_DECR, d);
      chk(d, 32'hFFFFFFFF);
      rr(REG_PEND, d);
      chk(d, 32'h1);
      wait_redir();
      chk(32'(nred), 32'h0);
      rw(REG_DECR, 32'h0);
      rw(REG_DECR, 32'h80000000);
      rr(REG_DECR, d);
      chk(d, 32'h80000000);
      m = $random(seed);
      m[31-MS_EE] = 1'h1;
      m[31-MS_SE] = 1'h0;
      m[31-MS_BE] = 1'h0;
      pc = u_pipe.pc_q;
      rw(REG_MSTATE, m);
      ent_chk(CEXU_DEC, m, VEC_DECR, pc, 32'h0, 1'h0);
      chk(32'(dec_pending_o), 32'h0);
      rw(REG_MSTATE, m);
      wait_redir();
      chk(32'(nred), 32'h0);
      $display("test decrementer done");
      wrap_up();
   end
endmodule
